/* File: rtl/acsl_map.svh */
// register offsets, field positions and reset values of the converter control block
// assumes it is included by bare name from design and verification files
`ifndef ACSL_MAP_SVH
`define ACSL_MAP_SVH

// register pointer values seen on the register port
`define ACSL_ADDR_RESULT 4'h0
`define ACSL_ADDR_ALERT 4'h1
`define ACSL_ADDR_CONFIG 4'h2
`define ACSL_ADDR_CYCLE 4'h3
`define ACSL_ADDR_LIMIT_BASE 4'h4

// configuration register fields
`define ACSL_CFG_POL 0
`define ACSL_CFG_SEL 1
`define ACSL_CFG_AEN 2
`define ACSL_CFG_FLTR 3
`define ACSL_CFG_MASK_LSB 4
`define ACSL_CFG_MASK_MSB 7
`define ACSL_CFG_RESET 8'h08

// result and limit word fields
`define ACSL_RES_FLAG 15
`define ACSL_RES_ZERO 14
`define ACSL_RES_TAG_MSB 13
`define ACSL_RES_TAG_LSB 12
`define ACSL_RES_VAL_MSB 11

// limit register reset values
`define ACSL_UPPER_RESET 12'hfff
`define ACSL_LOWER_RESET 12'h000
`define ACSL_HYST_RESET_12 12'h008
`define ACSL_HYST_RESET_10 12'h002

`endif

/* File: rtl/acsl_pkg.sv */
// types shared by the converter control block
// assumes acsl_map.svh holds the numeric constants
package acsl_pkg;

  // sequencer states, gray along idle -> convert -> idle
  typedef enum logic [1:0]
  {
    ACSL_IDLE = 2'b00,
    ACSL_CONV = 2'b01
  } acsl_seq_state_t;

  // which limit register of a channel a write lands in
  typedef enum logic [1:0]
  {
    ACSL_FLD_LOWER = 2'b00,
    ACSL_FLD_UPPER = 2'b01,
    ACSL_FLD_HYST = 2'b10,
    ACSL_FLD_NONE = 2'b11
  } acsl_field_t;

endpackage

/* File: rtl/acsl_channel_pick.sv */
// channel picker: next enabled input above the last converted one
// assumes mask and lastChan come from registers on the same clock
`timescale 1ns/10ps
module acsl_channel_pick
(
  input wire logic [3:0] mask, // enabled inputs, bit 0 is input one
  input wire logic [1:0] lastChan, // tag of the last converted input
  input wire logic restart, // begin again at the lowest enabled input
  output logic [1:0] nextChan, // tag of the input to convert next
  output logic anyEnabled // at least one input is enabled
);

  logic [1:0] lowest;
  logic [1:0] above;
  logic foundAbove;

  // scan from the top down so the lowest hit is kept last
  always_comb
  begin
    lowest = 2'h0;
    above = 2'h0;
    foundAbove = 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      if (mask[i])
      begin
        lowest = 2'(i);
        if (2'(i) > lastChan)
        begin
          above = 2'(i);
          foundAbove = 1'b1;
        end
      end
    end
    anyEnabled = |mask; // an empty mask selects nothing
    nextChan = (restart || !foundAbove) ? lowest : above;
  end

endmodule // acsl_channel_pick

/* File: rtl/acsl_channel_limit.sv */
// per-input limit registers and window comparator with hysteresis
// assumes evalEn pulses for one cycle with the code of this input
`timescale 1ns/10ps
`include "acsl_map.svh"
module acsl_channel_limit
#(
  parameter logic [11:0] HYST_RESET = `ACSL_HYST_RESET_12
)
(
  input wire logic clock, // 40 MHz system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic wrEn, // register write strobe
  input wire acsl_pkg::acsl_field_t wrField, // which register is written
  input wire logic [11:0] wrData, // used 12 bits of the written word
  input wire logic evalEn, // a conversion of this input just finished
  input wire logic [11:0] code, // the finished conversion value
  input wire logic clearCmd, // software clear of all violations
  output logic [11:0] upperLimit, // upper limit register
  output logic [11:0] lowerLimit, // lower limit register
  output logic [11:0] hysteresis, // hysteresis register
  output logic overActive, // upper violation still standing
  output logic underActive, // lower violation still standing
  output logic overEvent, // upper violation seen this cycle
  output logic underEvent // lower violation seen this cycle
);

  logic [11:0] upper_q, upper_d, lower_q, lower_d, hyst_q, hyst_d;
  logic over_q, over_d, under_q, under_d;
  logic [12:0] belowUpper, aboveLower;

  // strict compares; distances are taken one bit wider so they cannot wrap
  always_comb
  begin
    overEvent = evalEn && (code > upper_q);
    underEvent = evalEn && (code < lower_q);
    belowUpper = {1'b0, upper_q} - {1'b0, code};
    aboveLower = {1'b0, code} - {1'b0, lower_q};
  end

  // register writes and violation state; a new violation beats any clear
  always_comb
  begin
    upper_d = upper_q;
    lower_d = lower_q;
    hyst_d = hyst_q;
    if (wrEn && wrField == acsl_pkg::ACSL_FLD_UPPER)
      upper_d = wrData;
    if (wrEn && wrField == acsl_pkg::ACSL_FLD_LOWER)
      lower_d = wrData;
    if (wrEn && wrField == acsl_pkg::ACSL_FLD_HYST)
      hyst_d = wrData;
    over_d = over_q;
    if (overEvent)
      over_d = 1'b1;
    else if (clearCmd)
      over_d = 1'b0;
    else if (evalEn && belowUpper >= {1'b0, hyst_q})
      over_d = 1'b0;
    under_d = under_q;
    if (underEvent)
      under_d = 1'b1;
    else if (clearCmd)
      under_d = 1'b0;
    else if (evalEn && aboveLower >= {1'b0, hyst_q})
      under_d = 1'b0;
  end

  // full scale upper, zero scale lower after reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      upper_q <= `ACSL_UPPER_RESET;
      lower_q <= `ACSL_LOWER_RESET;
      hyst_q <= HYST_RESET;
      over_q <= 1'b0;
      under_q <= 1'b0;
    end
    else
    begin
      upper_q <= upper_d;
      lower_q <= lower_d;
      hyst_q <= hyst_d;
      over_q <= over_d;
      under_q <= under_d;
    end
  end

  assign upperLimit = upper_q;
  assign lowerLimit = lower_q;
  assign hysteresis = hyst_q;
  assign overActive = over_q;
  assign underActive = under_q;

endmodule // acsl_channel_limit

/* File: rtl/acsl_converter_control.sv */
// converter control top: sequencing, result word, limits, indicator pin
// assumes register port, start request and converter core all run on clock
// the serial bus controller and its register pointer sit outside this block
`timescale 1ns/10ps
`include "acsl_map.svh"
// Operation
// - four mask bits each enable one input; empty mask converts nothing
// - enabled inputs convert in ascending order from the lowest one
// - alert-enable and select both zero: indicator pin gives nothing
// - alert-enable zero, select one: indicator pin shows busy
// - alert-enable one, select zero: indicator pin shows alert
// - writing both bits one clears alert pin, flag and status bits
// - after that clear, configuration reads alert-enable one, select zero
// - latest conversion kept in read-only 16-bit straight binary word
// - word holds flag, zero, channel tag, then conversion value
// - tag codes inputs one to four as zero to three
// - value sits most significant bit first, top bit at bit 11
// - ten-bit variant reads zeros in the two lowest bits
// - flag set when this or any other input violated limits
// - each input has upper, lower and hysteresis of 12 used bits
// - reset upper limit is full scale, lower limit zero scale
// - value above upper limit sets flag and alert
// - value below lower limit sets flag and alert
// - upper violation ends when value is hysteresis codes below limit
// - lower violation ends when value is hysteresis codes above limit
// - polarity bit zero makes pin active low, one active high
// - status register keeps one upper and one lower bit per input
// - reset hysteresis is eight codes on the twelve-bit variant
module acsl_converter_control
#(
  parameter bit TEN_BIT = 1'b0 // 1 selects the ten-bit variant
)
(
  input wire logic clock, // 40 MHz system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic [3:0] regAddr, // register pointer value
  input wire logic [15:0] regWrData, // word written by the bus controller
  input wire logic regWrEn, // one-cycle write strobe
  output logic [15:0] regRdData, // registered read data for regAddr
  input wire logic convStart, // one-cycle request for one conversion
  output logic convReq, // one-cycle start pulse to the converter core
  output logic [1:0] convChan, // input tag the core must sample
  input wire logic convDone, // one-cycle pulse, core finished
  input wire logic [11:0] convCode, // finished straight binary value
  output logic indicatorOut, // level for the shared indicator pin
  output logic indicatorOe // high while the pin is driven
);

  localparam logic [11:0] HYST_RESET = TEN_BIT ? `ACSL_HYST_RESET_10 : `ACSL_HYST_RESET_12;

  acsl_pkg::acsl_seq_state_t state_q, state_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] alertStatus_q, alertStatus_d;
  logic [14:0] result_q, result_d;
  logic [1:0] lastChan_q, lastChan_d;
  logic fresh_q, fresh_d;
  logic convReq_q, convReq_d;
  logic [1:0] convChan_q, convChan_d;
  logic [15:0] rdData_q, rdData_d;
  logic indOut_q, indOut_d, indOe_q, indOe_d;

  logic [3:0] mask;
  logic [1:0] nextChan;
  logic anyEnabled;
  logic cfgWr, clearCmd, statusWr;
  logic [11:0] codeUsed;
  logic [3:0] limitWr;
  acsl_pkg::acsl_field_t limitField;
  logic [3:0] evalEn;
  logic [11:0] upperLimit [4];
  logic [11:0] lowerLimit [4];
  logic [11:0] hysteresis [4];
  logic [3:0] overActive, underActive, overEvent, underEvent;
  logic [7:0] statusSet;
  logic alertFlag;
  logic [1:0] rdChan;
  acsl_pkg::acsl_field_t rdField;

  assign mask = cfg_q[`ACSL_CFG_MASK_MSB:`ACSL_CFG_MASK_LSB];

  // chooses the next enabled input; restart after reset or a config write
  acsl_channel_pick u_pick
  (
    .mask(mask),
    .lastChan(lastChan_q),
    .restart(fresh_q),
    .nextChan(nextChan),
    .anyEnabled(anyEnabled)
  );

  // register write decode; limit pointers reuse the read-side decode
  // so a write and a read of one pointer can never disagree on the slice
  always_comb
  begin
    cfgWr = regWrEn && (regAddr == `ACSL_ADDR_CONFIG);
    statusWr = regWrEn && (regAddr == `ACSL_ADDR_ALERT);
    clearCmd = cfgWr && regWrData[`ACSL_CFG_AEN] && regWrData[`ACSL_CFG_SEL];
    limitWr = 4'h0;
    limitField = rdField;
    if (regWrEn && rdField != acsl_pkg::ACSL_FLD_NONE)
    begin
      limitWr[rdChan] = 1'b1;
    end
  end

  // ten-bit variant drops the two low bits before storing and comparing
  always_comb
  begin
    codeUsed = convCode;
    if (TEN_BIT)
      codeUsed[1:0] = 2'b00;
  end

  // only the input just converted is evaluated
  always_comb
  begin
    evalEn = 4'h0;
    if (state_q == acsl_pkg::ACSL_CONV && convDone)
      evalEn[convChan_q] = 1'b1;
  end

  // one limit slice per input
  for (genvar g = 0; g < 4; g++)
  begin : g_limit
    acsl_channel_limit #(.HYST_RESET(HYST_RESET)) u_limit
    (
      .clock(clock),
      .rst(rst),
      .wrEn(limitWr[g]),
      .wrField(limitField),
      .wrData(regWrData[11:0]),
      .evalEn(evalEn[g]),
      .code(codeUsed),
      .clearCmd(clearCmd),
      .upperLimit(upperLimit[g]),
      .lowerLimit(lowerLimit[g]),
      .hysteresis(hysteresis[g]),
      .overActive(overActive[g]),
      .underActive(underActive[g]),
      .overEvent(overEvent[g]),
      .underEvent(underEvent[g])
    );
    assign statusSet[2*g] = underEvent[g];
    assign statusSet[2*g+1] = overEvent[g];
  end

  // flag covers every input, not only the one in the result word
  assign alertFlag = |{overActive, underActive};

  // sequencer: a start is ignored while converting or with no input enabled
  always_comb
  begin
    state_d = state_q;
    lastChan_d = lastChan_q;
    fresh_d = fresh_q;
    convReq_d = 1'b0;
    convChan_d = convChan_q;
    result_d = result_q;
    case (state_q)
      acsl_pkg::ACSL_IDLE:
      begin
        if (convStart && anyEnabled)
        begin
          convReq_d = 1'b1;
          convChan_d = nextChan;
          lastChan_d = nextChan;
          fresh_d = 1'b0;
          state_d = acsl_pkg::ACSL_CONV;
        end
      end
      acsl_pkg::ACSL_CONV:
      begin
        if (convDone)
        begin
          result_d = {1'b0, convChan_q, codeUsed};
          state_d = acsl_pkg::ACSL_IDLE;
        end
      end
      default:
      begin
        state_d = acsl_pkg::ACSL_IDLE;
      end
    endcase
    if (cfgWr)
      fresh_d = 1'b1; // a new mask restarts from its lowest input
  end

  // configuration and status; a new violation wins over any clear
  always_comb
  begin
    cfg_d = cfg_q;
    if (cfgWr)
    begin
      cfg_d = regWrData[7:0];
      if (clearCmd)
        cfg_d[`ACSL_CFG_SEL] = 1'b0;
    end
    alertStatus_d = alertStatus_q;
    if (clearCmd)
      alertStatus_d = 8'h00;
    else if (statusWr)
      alertStatus_d = alertStatus_q & ~regWrData[7:0];
    alertStatus_d = alertStatus_d | statusSet;
  end

  // indicator pin role from alert-enable and select, level from polarity
  always_comb
  begin
    logic active;
    active = 1'b0;
    indOe_d = 1'b0;
    case ({cfg_q[`ACSL_CFG_AEN], cfg_q[`ACSL_CFG_SEL]})
      2'b00:
      begin
        indOe_d = 1'b0;
      end
      2'b01:
      begin
        indOe_d = 1'b1;
        active = (state_q == acsl_pkg::ACSL_CONV);
      end
      2'b10:
      begin
        indOe_d = 1'b1;
        active = alertFlag;
      end
      default:
      begin
        indOe_d = 1'b0; // select never stays set with alert-enable
      end
    endcase
    indOut_d = cfg_q[`ACSL_CFG_POL] ? active : ~active;
  end

  // read mux, one cycle of latency; unused bits and unmapped pointers read zero
  always_comb
  begin
    rdChan = 2'h0;
    rdField = acsl_pkg::ACSL_FLD_NONE;
    rdData_d = 16'h0000;
    // limit pointers run lower, upper, hysteresis per input from the base
    if (regAddr >= `ACSL_ADDR_LIMIT_BASE)
    begin
      rdChan = 2'((regAddr - `ACSL_ADDR_LIMIT_BASE) / 4'h3);
      rdField = acsl_pkg::acsl_field_t'(2'((regAddr - `ACSL_ADDR_LIMIT_BASE) % 4'h3));
    end
    case (regAddr)
      `ACSL_ADDR_RESULT: rdData_d = {alertFlag, result_q};
      `ACSL_ADDR_ALERT: rdData_d = {8'h00, alertStatus_q};
      `ACSL_ADDR_CONFIG: rdData_d = {8'h00, cfg_q};
      `ACSL_ADDR_CYCLE: rdData_d = 16'h0000;
      default:
      begin
        case (rdField)
          acsl_pkg::ACSL_FLD_LOWER: rdData_d = {alertFlag, 3'h0, lowerLimit[rdChan]};
          acsl_pkg::ACSL_FLD_UPPER: rdData_d = {alertFlag, 3'h0, upperLimit[rdChan]};
          acsl_pkg::ACSL_FLD_HYST: rdData_d = {alertFlag, 3'h0, hysteresis[rdChan]};
          default: rdData_d = 16'h0000;
        endcase
      end
    endcase
  end

  // all control state and outputs registered here
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= acsl_pkg::ACSL_IDLE;
      cfg_q <= `ACSL_CFG_RESET;
      alertStatus_q <= 8'h00;
      result_q <= 15'h0000;
      lastChan_q <= 2'h0;
      fresh_q <= 1'b1;
      convReq_q <= 1'b0;
      convChan_q <= 2'h0;
      rdData_q <= 16'h0000;
      indOut_q <= 1'b1;
      indOe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cfg_q <= cfg_d;
      alertStatus_q <= alertStatus_d;
      result_q <= result_d;
      lastChan_q <= lastChan_d;
      fresh_q <= fresh_d;
      convReq_q <= convReq_d;
      convChan_q <= convChan_d;
      rdData_q <= rdData_d;
      indOut_q <= indOut_d;
      indOe_q <= indOe_d;
    end
  end

  assign regRdData = rdData_q;
  assign convReq = convReq_q;
  assign convChan = convChan_q;
  assign indicatorOut = indOut_q;
  assign indicatorOe = indOe_q;

endmodule // acsl_converter_control

/* File: verification/acsl_converter_control_asserts.sv */
// checker for the converter control top, bound into every instance
// assumes no config write lands while a conversion is pending
`timescale 1ns/10ps
`include "acsl_map.svh"
module acsl_converter_control_asserts
#(
  parameter bit TEN_BIT = 1'b0
)
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire logic [3:0] regAddr, // pointer
  input wire logic [15:0] regWrData, // write word
  input wire logic regWrEn, // write strobe
  input wire logic [15:0] regRdData, // read word
  input wire logic convStart, // request
  input wire logic convReq, // core start
  input wire logic [1:0] convChan, // input tag
  input wire logic convDone, // core done
  input wire logic [11:0] convCode, // core value
  input wire logic indicatorOut, // pin level
  input wire logic indicatorOe // pin enable
);
  logic [7:0] cfgQ, cfgD;
  logic busyQ, busyD, restartQ, restartD, startOk, clearWr;
  logic [1:0] lastQ, lastD, ageQ, ageD, nextChan;
  logic [11:0] codeQ, codeD;

  assign startOk = convStart && cfgQ[7:4] != 4'h0 && !busyQ;
  assign clearWr = regWrEn && regAddr == 4'h2 && regWrData[2:1] == 2'b11;

  // lowest enabled input above the last one, else the lowest enabled
  always_comb
  begin
    nextChan = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (cfgQ[4 + i]) nextChan = 2'(i);
    if (!restartQ)
      for (int i = 3; i >= 0; i--)
        if (cfgQ[4 + i] && i > int'(lastQ)) nextChan = 2'(i);
  end

  // mirror rebuilt from port traffic only
  always_comb
  begin
    cfgD = cfgQ;
    busyD = busyQ;
    restartD = restartQ;
    lastD = lastQ;
    codeD = codeQ;
    ageD = (ageQ == 2'h3) ? ageQ : ageQ + 2'h1;
    if (regWrEn && regAddr == 4'h2)
    begin
      cfgD = {regWrData[7:2], regWrData[1] & ~regWrData[2], regWrData[0]};
      restartD = 1'b1;
    end
    if (startOk)
      busyD = 1'b1;
    else if (convDone)
      busyD = 1'b0;
    if (convReq)
    begin
      lastD = convChan;
      restartD = 1'b0;
    end
    if (convDone && busyQ)
    begin
      codeD = convCode;
      ageD = 2'h0;
    end
  end

  // registers of the mirror
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cfgQ <= `ACSL_CFG_RESET;
      busyQ <= 1'b0;
      restartQ <= 1'b1;
      lastQ <= 2'h0;
      ageQ <= 2'h3;
      codeQ <= 12'h000;
    end
    else
    begin
      cfgQ <= cfgD;
      busyQ <= busyD;
      restartQ <= restartD;
      lastQ <= lastD;
      ageQ <= ageD;
      codeQ <= codeD;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_no_req_empty;
    convStart && cfgQ[7:4] == 4'h0 |=> !convReq;
  endproperty
  a_no_req_empty: assert property (p_no_req_empty) else $error("start taken with empty mask");
  property p_req_on_start;
    startOk |=> convReq ##1 !convReq;
  endproperty
  a_req_on_start: assert property (p_req_on_start) else $error("start not answered");
  property p_ascending;
    convReq |-> convChan == nextChan;
  endproperty
  a_ascending: assert property (p_ascending) else $error("wrong input order");
  property p_oe_mode;
    indicatorOe == $past(cfgQ[2] | cfgQ[1]);
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("pin enable off role");
  property p_busy_pin;
    cfgQ[2:1] == 2'b01 && convReq |=> indicatorOut == cfgQ[0];
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("busy level wrong");
  property p_clear_read;
    clearWr ##1 regAddr == 4'h2 |=> regRdData[2:1] == 2'b10;
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("clear readback wrong");
  property p_clear_flag;
    clearWr && !busyQ ##3 regAddr == 4'h0 |=> !regRdData[15];
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("flag kept after clear");
  property p_limit_zero;
    regAddr >= 4'h4 |=> regRdData[14:12] == 3'h0;
  endproperty
  a_limit_zero: assert property (p_limit_zero) else $error("limit upper bits set");
  property p_result_word;
    ageQ == 2'h3 && !busyQ && regAddr == 4'h0
      |=> regRdData[14:0] == {1'b0, lastQ, codeQ[11:2], TEN_BIT ? 2'b00 : codeQ[1:0]};
  endproperty
  a_result_word: assert property (p_result_word) else $error("result word wrong");
endmodule // acsl_converter_control_asserts

bind acsl_converter_control acsl_converter_control_asserts #(.TEN_BIT(TEN_BIT))
  i_acsl_converter_control_asserts (.clock(clock), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData), .convStart(convStart),
  .convReq(convReq), .convChan(convChan), .convDone(convDone), .convCode(convCode),
  .indicatorOut(indicatorOut), .indicatorOe(indicatorOe));

/* File: verification/acsl_core_model.sv */
// converter core model: one answer per start pulse, fast or slow
// assumes start pulses arrive only while it is idle
`timescale 1ns/10ps
module acsl_core_model
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire logic convReq, // start pulse
  input wire logic [1:0] convChan, // input to sample
  input wire logic slow, // long conversion time
  input wire logic [47:0] codeTable, // value per input, input one lowest
  output logic convDone, // finished pulse
  output logic [11:0] convCode // value with convDone, scrambled otherwise
);
  logic [3:0] waitQ;
  logic [1:0] chanQ;

  // count down from a start, answer once; data toggles between answers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      waitQ <= 4'h0;
      chanQ <= 2'h0;
      convDone <= 1'b0;
      convCode <= 12'h5a5;
    end
    else
    begin
      convDone <= 1'b0;
      convCode <= ~convCode;
      if (convReq)
      begin
        waitQ <= slow ? 4'h9 : 4'h1;
        chanQ <= convChan;
      end
      else if (waitQ == 4'h1)
      begin
        waitQ <= 4'h0;
        convDone <= 1'b1;
        convCode <= codeTable[chanQ * 12 +: 12];
      end
      else if (waitQ != 4'h0)
        waitQ <= waitQ - 4'h1;
    end
  end
endmodule // acsl_core_model

/* File: verification/test_acsl_converter_control.sv */
// self-checking bench for the converter control top and a ten-bit twin
// assumes the core model answers each start pulse once
`timescale 1ns/10ps
`include "acsl_map.svh"
module test_acsl_converter_control;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWrEn = 1'b0;
  logic convStart = 1'b0;
  logic slow = 1'b0;
  logic [47:0] codeTable = 48'h0;
  logic [15:0] regRdData, tenRdData, resWord;
  logic convReq, convDone, indicatorOut, indicatorOe, restart;
  logic [1:0] convChan, last, c;
  logic [11:0] convCode, code;
  logic [11:0] lim [12];
  logic [7:0] cfg, status;
  logic [3:0] overA, underA;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  acsl_converter_control i_acsl_converter_control (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData), .convStart(convStart),
    .convReq(convReq), .convChan(convChan), .convDone(convDone), .convCode(convCode),
    .indicatorOut(indicatorOut), .indicatorOe(indicatorOe));
  acsl_converter_control #(.TEN_BIT(1'b1)) i_acsl_converter_control_ten (.clock(clock),
    .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdData(tenRdData), .convStart(convStart), .convReq(), .convChan(), .convDone(convDone),
    .convCode(convCode), .indicatorOut(), .indicatorOe());
  acsl_core_model i_acsl_core_model (.clock(clock), .rst(rst), .convReq(convReq),
    .convChan(convChan), .slow(slow), .codeTable(codeTable), .convDone(convDone),
    .convCode(convCode));

  // 40 MHz clock and a hang limit far above the expected run
  always #12.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(string what, logic [15:0] seen, logic [15:0] want);
    compares++;
    if (seen !== want)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask

  // write costs two edges so the strobe never rises in the step it fell
  task automatic wr(logic [3:0] a, logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clock);
    #1;
    regWrEn = 1'b0;
    if (a == 4'h1) status = status & ~d[7:0];
    if (a >= 4'h4) lim[a - 4'h4] = d[11:0];
    if (a == 4'h2)
    begin
      cfg = {d[7:2], d[1] & ~d[2], d[0]};
      restart = 1'b1;
      if (d[2:1] == 2'b11)
      begin
        overA = 4'h0;
        underA = 4'h0;
        status = 8'h00;
      end
    end
    @(posedge clock);
    #1;
  endtask

  function automatic logic [15:0] regWant(logic [3:0] a);
    logic f;
    f = |{overA, underA};
    case (a)
      4'h0: return {f, resWord[14:0]};
      4'h1: return {8'h00, status};
      4'h2: return {8'h00, cfg};
      4'h3: return 16'h0000;
      default: return {f, 3'h0, lim[a - 4'h4]};
    endcase
  endfunction

  task automatic rd(logic [3:0] a);
    regAddr = a;
    @(posedge clock);
    #1;
    check($sformatf("reg %h", a), regRdData, regWant(a));
  endtask

  task automatic pinCheck();
    logic act;
    logic oe;
    act = (cfg[2:1] == 2'b10 && |{overA, underA}) ? cfg[0] : ~cfg[0];
    oe = cfg[2] | cfg[1];
    check("pin", {14'h0, indicatorOe, indicatorOe & (indicatorOut ~^ act)}, {14'h0, oe, oe});
  endtask

  function automatic logic [1:0] nextCh();
    logic [1:0] n;
    n = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (cfg[4 + i]) n = 2'(i);
    if (!restart)
      for (int i = 3; i >= 0; i--)
        if (cfg[4 + i] && i > int'(last)) n = 2'(i);
    return n;
  endfunction

  // one conversion; a slow one also meets a refused second start
  task automatic conv();
    int n;
    c = nextCh();
    codeTable[c * 12 +: 12] = code;
    convStart = 1'b1;
    @(posedge clock);
    #1;
    convStart = 1'b0;
    check("convReq", {15'h0, convReq}, 16'h0001);
    check("convChan", {14'h0, convChan}, {14'h0, c});
    last = c;
    restart = 1'b0;
    @(posedge clock);
    #1;
    if (cfg[2:1] == 2'b01) check("busy", {15'h0, indicatorOut}, {15'h0, cfg[0]});
    n = 0;
    while (convDone !== 1'b1 && n < 30)
    begin
      convStart = (n == 2) && slow;
      @(posedge clock);
      #1;
      n++;
      check("refused", {15'h0, convReq}, 16'h0000);
    end
    if (code > lim[3 * c + 1])
    begin
      overA[c] = 1'b1;
      status[2 * c + 1] = 1'b1;
    end
    else if (lim[3 * c + 1] - code >= lim[3 * c + 2]) overA[c] = 1'b0;
    if (code < lim[3 * c])
    begin
      underA[c] = 1'b1;
      status[2 * c] = 1'b1;
    end
    else if (code - lim[3 * c] >= lim[3 * c + 2]) underA[c] = 1'b0;
    resWord = {2'b00, c, code};
    repeat (2) @(posedge clock);
    #1;
    pinCheck();
    rd(4'h0);
    check("tenWord", {2'h0, tenRdData[13:0]}, {2'h0, c, code[11:2], 2'b00});
    rd(4'h1);
  endtask

  // reset values, refusals, then random traffic with boundary codes
  initial
  begin
    void'($urandom(59));
    cfg = `ACSL_CFG_RESET;
    status = 8'h00;
    overA = 4'h0;
    underA = 4'h0;
    restart = 1'b1;
    last = 2'h0;
    resWord = 16'h0000;
    for (int k = 0; k < 12; k++)
      lim[k] = k % 3 == 1 ? `ACSL_UPPER_RESET : (k % 3 == 2 ? `ACSL_HYST_RESET_12 : 12'h000);
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    for (int a = 0; a < 16; a++) rd(4'(a));
    check("tenHyst", tenRdData, 16'h0002);
    wr(4'h0, 16'hffff);
    wr(4'h3, 16'h0005);
    rd(4'h0);
    rd(4'h3);
    wr(4'h2, 16'h0002);
    pinCheck();
    convStart = 1'b1;
    repeat (2)
    begin
      @(posedge clock);
      #1;
      convStart = 1'b0;
      check("emptyMask", {15'h0, convReq}, 16'h0000);
    end
    for (int r = 0; r < 48; r++)
    begin
      if (r % 8 == 0) wr(4'h2, {8'h00, 4'($urandom_range(1, 15)), 1'b1, 2'(r / 8 % 3), 1'($urandom)});
      n_lim(4'($urandom_range(0, 11)));
      c = nextCh();
      case ($urandom % 5)
        0: code = 12'($urandom);
        1: code = lim[3 * c + 1] + 12'h001;
        2: code = lim[3 * c + 1] - lim[3 * c + 2];
        3: code = lim[3 * c] - 12'h001;
        default: code = lim[3 * c] + lim[3 * c + 2];
      endcase
      slow = 1'($urandom);
      conv();
      if (r % 6 == 5) wr(4'h1, {8'h00, 8'($urandom)});
      if (r % 16 == 15)
      begin
        wr(4'h2, {8'h00, cfg[7:3], 2'b11, cfg[0]});
        rd(4'h2);
        rd(4'h0);
        pinCheck();
      end
    end
    for (int a = 0; a < 16; a++) rd(4'(a));
    wr(4'h1, 16'h00ff);
    rd(4'h1);
    close_out();
  end

  // limit writes keep the two lowest bits clear; hysteresis stays small
  task automatic n_lim(logic [3:0] k);
    wr(4'h4 + k, {4'h0, 12'($urandom) & (k % 3 == 2 ? 12'h03c : 12'hffc)});
  endtask
endmodule // test_acsl_converter_control
